/* File: rtl/pstm_pkg.sv */
// package for the power-state and thermal manager
package pstm_pkg;
   localparam int QUIET_T_DEFAULT = 10000;
   localparam int QUIET_W = 32;
   localparam logic [6:0] EEPROM_ADDR = 7'h50;
   localparam int EE_WAIT_CYC = 16;

   typedef enum logic [1:0] {PS_ACTIVE, PS_IDLE, PS_SLEEP} pstm_pstate_t;
   typedef enum logic [1:0] {BT_PROBE, BT_EE_LOAD, BT_HOST_WAIT, BT_DONE} pstm_boot_t;
   typedef enum logic [1:0] {CC_OPEN, CC_RD, CC_RP_3A0} pstm_cc_t;

   // activity sources that restart the idle timer
   typedef struct packed {
      logic pd_msg;
      logic cc_change;
      logic gpio_event;
      logic i2c_txn;
      logic volt_alert;
      logic fault_alert;
   } pstm_activity_t;

   // path enables and cc terminations driven out
   typedef struct packed {
      logic port_a_source_path;
      logic port_b_source_path;
      logic [1:0] external_sink_path;
      logic [1:0] cable_supply_path;
      pstm_cc_t port_a_first_cc;
      pstm_cc_t port_b_first_cc;
   } pstm_paths_t;

   typedef struct packed {
      pstm_pstate_t pstate;
      logic standby;
      logic [QUIET_W-1:0] quiet_cnt;
      logic die_shut;
      logic path_shut;
      pstm_boot_t boot;
      logic [7:0] boot_cnt;
      logic ee_req;
      pstm_paths_t paths;
   } pstm_state_t;
endpackage

/* File: rtl/pstm_manager.sv */
// power-state, path-enable and thermal shutdown manager
`timescale 1ns/1ps
// Notes on behaviour
// - exactly one state: active, idle, sleep
// - active to idle after quiet interval
// - state changes autonomous, no host command
// - sleep watches for attach, wakes
// - source/sink path and cc table
// - standby port a only; sleep all off
// - die overtemp disables all but supervision
// - die resumes below threshold minus hysteresis
// - path overtemp kills sources and cable supply
// - path recovery auto or firmware re-enable
// - config from host or eeprom at boot
// - probe eeprom 0x50 first, else host
module pstm_manager import pstm_pkg::*; #(
   parameter int QUIET_T = QUIET_T_DEFAULT
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire pstm_activity_t activity_i,
   input wire logic sink_mode_i,
   input wire logic standby_req_i,
   input wire logic sleep_allowed_i,
   input wire logic attach_i,
   input wire logic die_over_i,
   input wire logic die_below_hyst_i,
   input wire logic path_over_i,
   input wire logic path_cooled_i,
   input wire logic path_auto_resume_i,
   input wire logic fw_path_enable_i,
   input wire logic ee_ack_i,
   input wire logic ee_nack_i,
   input wire logic ee_load_done_i,
   input wire logic host_load_done_i,
   output logic ee_req_o,
   output logic [6:0] ee_addr_o,
   output logic config_loaded_o,
   output pstm_pstate_t pstate_o,
   output logic standby_o,
   output logic die_shut_o,
   output logic path_shut_o,
   output pstm_paths_t paths_o
);
   localparam logic [QUIET_W-1:0] QUIET_LAST = QUIET_W'(QUIET_T - 1);
   localparam logic [7:0] EE_LAST = 8'(EE_WAIT_CYC - 1);
   localparam logic [QUIET_W-1:0] QUIET_ONE = QUIET_W'(1);
   // every path off and every termination open; named members keep the cc enums legal
   localparam pstm_paths_t PATHS_OFF = '{port_a_first_cc: CC_OPEN, port_b_first_cc: CC_OPEN,
      default: '0};

   pstm_state_t st, next_st;
   logic any_act;

   assign any_act = |activity_i;

   // one next-state process for all control
   always_comb begin
      next_st = st;
      // probe request only stands while the probe state asks for it
      next_st.ee_req = 1'b0;
      // boot: eeprom probe then host fallback
      case (st.boot)
         BT_PROBE: begin
            next_st.ee_req = 1'b1;
            next_st.boot_cnt = st.boot_cnt + 8'h01;
            if (ee_ack_i) begin
               next_st.boot = BT_EE_LOAD;
            end else if (ee_nack_i || st.boot_cnt == EE_LAST) begin
               next_st.boot = BT_HOST_WAIT; // no eeprom answered
            end
         end
         BT_EE_LOAD: begin
            if (ee_load_done_i) begin
               next_st.boot = BT_DONE;
            end
         end
         BT_HOST_WAIT: begin
            if (host_load_done_i) begin
               next_st.boot = BT_DONE;
            end
         end
         default: next_st.boot = BT_DONE;
      endcase
      // die shutdown holds until hysteresis is cleared
      // the state walk keeps running underneath, so timing is current on recovery
      if (die_over_i) begin
         next_st.die_shut = 1'b1;
      end else if (st.die_shut && die_below_hyst_i) begin
         next_st.die_shut = 1'b0;
      end
      // path shutdown, recovery per configuration
      // an overtemp in the same cycle as a release wins, so a hot path never reopens
      if (path_over_i) begin
         next_st.path_shut = 1'b1;
      end else if (st.path_shut && path_cooled_i && (path_auto_resume_i || fw_path_enable_i)) begin
         next_st.path_shut = 1'b0;
      end
      // autonomous power-state walk
      case (st.pstate)
         PS_ACTIVE: begin
            if (any_act) begin
               next_st.quiet_cnt = '0;
            end else if (st.quiet_cnt == QUIET_LAST) begin
               next_st.pstate = PS_IDLE;
               next_st.quiet_cnt = '0;
            end else begin
               next_st.quiet_cnt = st.quiet_cnt + QUIET_ONE;
            end
         end
         PS_IDLE: begin
            // standby follows the request only while idle
            next_st.standby = standby_req_i;
            if (any_act) begin
               next_st.pstate = PS_ACTIVE;
               next_st.standby = 1'b0;
            end else if (sleep_allowed_i && !attach_i) begin
               next_st.pstate = PS_SLEEP;
               next_st.standby = 1'b0;
            end
         end
         PS_SLEEP: begin
            // attach watch stays alive in sleep
            if (attach_i || any_act) begin
               next_st.pstate = PS_ACTIVE;
               next_st.quiet_cnt = '0;
            end
         end
         default: next_st.pstate = PS_ACTIVE;
      endcase
      // path table per state and role
      next_st.paths = PATHS_OFF;
      if (st.pstate != PS_SLEEP && !st.die_shut) begin
         if (st.standby) begin
            next_st.paths.port_a_source_path = !sink_mode_i;
            next_st.paths.port_a_first_cc = sink_mode_i ? CC_RP_3A0 : CC_RD;
            next_st.paths.port_b_first_cc = CC_OPEN;
         end else begin
            next_st.paths.port_a_source_path = !sink_mode_i;
            next_st.paths.port_b_source_path = !sink_mode_i;
            next_st.paths.external_sink_path = {2{sink_mode_i}};
            next_st.paths.cable_supply_path = 2'b11;
            next_st.paths.port_a_first_cc = sink_mode_i ? CC_RP_3A0 : CC_RD;
            next_st.paths.port_b_first_cc = sink_mode_i ? CC_RP_3A0 : CC_RD;
         end
         if (st.path_shut) begin
            next_st.paths.port_a_source_path = 1'b0;
            next_st.paths.port_b_source_path = 1'b0;
            next_st.paths.cable_supply_path = 2'b00;
         end
      end
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         st <= '{pstate: PS_ACTIVE, boot: BT_PROBE, paths: PATHS_OFF, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // outputs come straight from the state register, except the eeprom address, which is the fixed EEPROM_ADDR, and config_loaded_o, a decode of st.boot == BT_DONE
   assign ee_req_o = st.ee_req;
   assign ee_addr_o = EEPROM_ADDR;
   assign config_loaded_o = (st.boot == BT_DONE);
   assign pstate_o = st.pstate;
   assign standby_o = st.standby;
   assign die_shut_o = st.die_shut;
   assign path_shut_o = st.path_shut;
   assign paths_o = st.paths;

   // checks on state, timer, shutdown and boot
   a_state_legal: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate inside {PS_ACTIVE, PS_IDLE, PS_SLEEP}) else $error("illegal power state");
   a_idle_needs_quiet: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $past(st.pstate) == PS_ACTIVE && st.pstate == PS_IDLE |-> $past(st.quiet_cnt) == QUIET_LAST)
      else $error("idle entered early");
   a_act_restarts: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate == PS_ACTIVE && any_act |=> st.quiet_cnt == '0) else $error("timer not restarted");
   a_sleep_wake: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate == PS_SLEEP && attach_i |=> st.pstate == PS_ACTIVE) else $error("attach missed");
   a_sleep_all_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate == PS_SLEEP |=> paths_o == '0) else $error("path on in sleep");
   a_die_kills_all: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      die_over_i |=> ##1 paths_o == '0) else $error("die shutdown leak");
   a_die_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.die_shut && !die_below_hyst_i |=> st.die_shut) else $error("die shutdown released early");
   a_path_kills: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      path_over_i |=> ##1 !paths_o.port_a_source_path && !paths_o.port_b_source_path
      && paths_o.cable_supply_path == 2'b00) else $error("path shutdown leak");
   a_path_manual: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.path_shut && !path_auto_resume_i && !fw_path_enable_i |=> st.path_shut)
      else $error("path resumed without firmware");
   a_probe_first: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $past(st.boot) == BT_PROBE && st.boot == BT_HOST_WAIT |-> $past(ee_nack_i) || $past(st.boot_cnt) == EE_LAST)
      else $error("host wait without eeprom miss");
   // role tables: full table outside standby while no shutdown flag is up
   a_source_table: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate != PS_SLEEP && !st.standby && !st.die_shut && !st.path_shut && !sink_mode_i
      |=> paths_o.port_a_source_path && paths_o.port_b_source_path && paths_o.external_sink_path == 2'b00
      && paths_o.cable_supply_path == 2'b11 && paths_o.port_a_first_cc == CC_RD
      && paths_o.port_b_first_cc == CC_RD) else $error("source table wrong");
   a_sink_table: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate != PS_SLEEP && !st.standby && !st.die_shut && !st.path_shut && sink_mode_i
      |=> !paths_o.port_a_source_path && !paths_o.port_b_source_path && paths_o.external_sink_path == 2'b11
      && paths_o.cable_supply_path == 2'b11 && paths_o.port_a_first_cc == CC_RP_3A0
      && paths_o.port_b_first_cc == CC_RP_3A0) else $error("sink table wrong");
   a_standby_paths: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate != PS_SLEEP && st.standby && !st.die_shut
      |=> !paths_o.port_b_source_path && paths_o.external_sink_path == 2'b00
      && paths_o.cable_supply_path == 2'b00 && paths_o.port_b_first_cc == CC_OPEN) else $error("standby leak");
   // a loaded bundle is the only way out of either boot wait
   a_ee_load_waits: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.boot == BT_EE_LOAD && !ee_load_done_i |=> st.boot == BT_EE_LOAD) else $error("eeprom load cut short");
   a_host_load_waits: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.boot == BT_HOST_WAIT && !host_load_done_i |=> st.boot == BT_HOST_WAIT) else $error("host load cut short");
   // activity ends idle, and a live attach keeps the part out of sleep
   a_idle_wakes: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate == PS_IDLE && any_act |=> st.pstate == PS_ACTIVE) else $error("idle ignored activity");
   a_attach_blocks_sleep: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      st.pstate == PS_IDLE && attach_i |=> st.pstate != PS_SLEEP) else $error("slept with attach");
endmodule

/* File: bench/pstm_ee_model.sv */
// eeprom stand-in that answers the boot probe of the manager
`timescale 1ns/1ps
module pstm_ee_model import pstm_pkg::*; (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic present_i,
   input wire logic nack_i,
   input wire logic ee_req_i,
   input wire logic [6:0] ee_addr_i,
   output logic ee_ack_o,
   output logic ee_nack_o,
   output logic ee_load_done_o
);
   logic [3:0] cnt;
   // an absent part refuses its address or stays silent, so the manager falls back to the host on the nack or on its timeout
   always_ff @(posedge ref_clk_i) begin
      ee_ack_o <= 1'b0;
      ee_nack_o <= 1'b0;
      ee_load_done_o <= 1'b0;
      if (!resetn_i) begin
         cnt <= 4'h0;
      end else if (cnt != 4'h0) begin
         cnt <= cnt + 4'h1;
         ee_load_done_o <= (cnt == 4'h6);
      end else if (ee_req_i && ee_addr_i == EEPROM_ADDR) begin
         if (present_i) begin
            cnt <= 4'h1;
            ee_ack_o <= 1'b1;
         end else begin
            ee_nack_o <= nack_i;
         end
      end
   end
endmodule

/* File: bench/pstm_manager_tb.sv */
// self-checking bench for the power-state and thermal manager
`timescale 1ns/1ps
module pstm_manager_tb import pstm_pkg::*; ;
   localparam int Q = 20;
   typedef struct packed {logic sink; logic stby; pstm_paths_t exp;} pstm_row_t;
   logic clk, rstn, sink, stby, slp, att, dov, dbh, pov, pcl, par, fwe, hld, prs, ack, ldn, req, cfg, sb, dsh, psh;
   logic nak, nck;
   logic [6:0] adr;
   pstm_activity_t act;
   pstm_pstate_t ps;
   pstm_paths_t pth;
   int fails = 0;
   int compares = 0;
   // role and standby against the idle path table
   pstm_row_t rows [4] = '{'{1'b0, 1'b0, '{1'b1, 1'b1, 2'b00, 2'b11, CC_RD, CC_RD}},
      '{1'b1, 1'b0, '{1'b0, 1'b0, 2'b11, 2'b11, CC_RP_3A0, CC_RP_3A0}},
      '{1'b0, 1'b1, '{1'b1, 1'b0, 2'b00, 2'b00, CC_RD, CC_OPEN}},
      '{1'b1, 1'b1, '{1'b0, 1'b0, 2'b00, 2'b00, CC_RP_3A0, CC_OPEN}}};
   pstm_manager #(.QUIET_T(Q)) i_pstm_manager (.ref_clk_i(clk), .resetn_i(rstn), .activity_i(act),
      .sink_mode_i(sink), .standby_req_i(stby), .sleep_allowed_i(slp), .attach_i(att), .die_over_i(dov),
      .die_below_hyst_i(dbh), .path_over_i(pov), .path_cooled_i(pcl), .path_auto_resume_i(par),
      .fw_path_enable_i(fwe), .ee_ack_i(ack), .ee_nack_i(nck), .ee_load_done_i(ldn), .host_load_done_i(hld),
      .ee_req_o(req), .ee_addr_o(adr), .config_loaded_o(cfg), .pstate_o(ps), .standby_o(sb),
      .die_shut_o(dsh), .path_shut_o(psh), .paths_o(pth));
   pstm_ee_model i_pstm_ee_model (.ref_clk_i(clk), .resetn_i(rstn), .present_i(prs), .nack_i(nak), .ee_req_i(req),
      .ee_addr_i(adr), .ee_ack_o(ack), .ee_nack_o(nck), .ee_load_done_o(ldn));
   task automatic stop_test();
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // inputs only move on the falling edge, away from sampling
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(input int b);
      act = 6'h01 << b;
      wt(1);
      act = '0;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard, far above the few hundred cycles the run needs
   initial begin
      wt(2000);
      fails++;
      stop_test();
   end
   initial begin
      {rstn, sink, stby, slp, att, dov, dbh, pov, pcl, par, fwe, hld, nak} = '0;
      act = '0;
      prs = 1'b1;
      wt(16);
      chk(ps, PS_ACTIVE);
      chk(adr, EEPROM_ADDR);
      rstn = 1'b1;
      for (int i = 0; i < 40 && cfg !== 1'b1; i++) begin
         wt(1);
      end
      chk(cfg, 1'b1);
      if (cfg !== 1'b1) begin
         stop_test();
      end
      // second activity restarts the quiet count, so idle comes late
      for (int r = 0; r < 4; r++) begin
         sink = rows[r].sink;
         stby = rows[r].stby;
         pulse(r);
         wt(Q / 2);
         pulse(r + 2);
         wt(Q - 3);
         chk(ps, PS_ACTIVE);
         chk(pth, rows[r % 2].exp);
         wt(6);
         chk(ps, PS_IDLE);
         chk(sb, rows[r].stby);
         chk(pth, rows[r].exp);
      end
      slp = 1'b1;
      wt(3);
      chk(ps, PS_SLEEP);
      chk(pth, 16'h0);
      {att, slp, sink, stby} = 4'h8;
      wt(3);
      chk(ps, PS_ACTIVE);
      // die shutdown holds until the hysteresis flag, not the threshold
      dov = 1'b1;
      wt(3);
      chk(dsh, 1'b1);
      chk(pth, 16'h0);
      dov = 1'b0;
      wt(3);
      chk(dsh, 1'b1);
      dbh = 1'b1;
      wt(3);
      chk(dsh, 1'b0);
      chk(pth[9:4], 6'h33);
      pov = 1'b1;
      wt(3);
      chk(psh, 1'b1);
      chk(pth[9:4], 6'h00);
      {pov, pcl} = 2'b01;
      wt(3);
      chk(psh, 1'b1);
      fwe = 1'b1;
      wt(1);
      fwe = 1'b0;
      wt(3);
      chk(psh, 1'b0);
      chk(pth[9:4], 6'h33);
      {par, pov} = 2'b11;
      wt(3);
      chk(psh, 1'b1);
      pov = 1'b0;
      wt(3);
      chk(psh, 1'b0);
      // no eeprom: probe times out and the host supplies the bundle
      {prs, rstn} = 2'b00;
      wt(2);
      rstn = 1'b1;
      wt(3);
      chk(req, 1'b1);
      wt(20);
      chk(req, 1'b0);
      chk(cfg, 1'b0);
      hld = 1'b1;
      wt(1);
      hld = 1'b0;
      wt(3);
      chk(cfg, 1'b1);
      // absent eeprom that refuses its address: the probe ends long before the timeout
      {nak, rstn} = 2'b10;
      wt(2);
      rstn = 1'b1;
      wt(5);
      chk(req, 1'b0);
      chk(cfg, 1'b0);
      hld = 1'b1;
      wt(1);
      hld = 1'b0;
      wt(3);
      chk(cfg, 1'b1);
      stop_test();
   end
endmodule
